// ==== logic/dfs_pkg.sv ====
package dfs_pkg;
   localparam int DFS_NUM_CH = 4;
   localparam int DFS_ADDR_W = 8;
   localparam int DFS_DATA_W = 8;

   // register addresses
   localparam logic [7:0] DFS_ADDR_LOAD_CH12 = 8'h0c;
   localparam logic [7:0] DFS_ADDR_LOAD_CH34 = 8'h0d;
   localparam logic [7:0] DFS_ADDR_LINE_OUT = 8'h0e;
   localparam logic [7:0] DFS_ADDR_STATE = 8'h0f;
   localparam logic [7:0] DFS_ADDR_CH_FAULT = 8'h10;
   localparam logic [7:0] DFS_ADDR_GLB_FAULT = 8'h11;

   // reset values
   localparam logic [7:0] DFS_RST_ZERO = 8'h00;
   localparam logic [7:0] DFS_RST_STATE = 8'h55;

   // per-channel load result nibble layout
   localparam int DFS_LOAD_S2G_BIT = 3;
   localparam int DFS_LOAD_S2P_BIT = 2;
   localparam int DFS_LOAD_OL_BIT = 1;
   localparam int DFS_LOAD_SL_BIT = 0;
   localparam int DFS_NIBBLE_W = 4;

   // global fault bit positions
   localparam int DFS_GLB_CLOCK_BIT = 4;
   localparam int DFS_GLB_PSOV_BIT = 3;
   localparam int DFS_GLB_BATOV_BIT = 2;
   localparam int DFS_GLB_PSUV_BIT = 1;
   localparam int DFS_GLB_BATUV_BIT = 0;

   // channel operating state encoding
   typedef enum logic [1:0] {
      DFS_ST_PLAY = 2'b00,
      DFS_ST_HIZ = 2'b01,
      DFS_ST_MUTE = 2'b10,
      DFS_ST_DIAG = 2'b11
   } dfs_state_e;

   typedef struct packed {
      logic [7:0] load_report_ch12;
      logic [7:0] load_report_ch34;
      logic [7:0] line_output_report;
      logic [7:0] channel_state_report;
      logic [7:0] channel_fault_flags;
      logic [7:0] global_fault_flags_one;
   } dfs_regs_s;
endpackage

// ==== logic/dfs_status_if.sv ====
`timescale 1ns/100ps
interface dfs_status_if;
   import dfs_pkg::*;
   dfs_regs_s regs;
   modport bank (output regs);
   modport reader (input regs);
endinterface

// ==== logic/dfs_read_mux.sv ====
`timescale 1ns/100ps
module dfs_read_mux
   import dfs_pkg::*;
(
   input wire logic clk_in, // clock
   input wire logic reset_in, // sync reset
   dfs_status_if.reader stat, // register contents
   input wire logic rd_en_in, // read strobe
   input wire logic [DFS_ADDR_W-1:0] rd_addr_in, // read address
   output logic [DFS_DATA_W-1:0] rd_data_out, // read data
   output logic rd_valid_out // read data valid
);
   typedef struct packed {
      logic [7:0] data;
      logic valid;
   } dfs_rd_s;

   dfs_rd_s st_q, st_d;

   // address decode; unmapped addresses read zero
   always_comb begin
      st_d = st_q;
      st_d.valid = rd_en_in;
      if (rd_en_in) begin
         unique case (rd_addr_in)
            DFS_ADDR_LOAD_CH12: st_d.data = stat.regs.load_report_ch12;
            DFS_ADDR_LOAD_CH34: st_d.data = stat.regs.load_report_ch34;
            DFS_ADDR_LINE_OUT: st_d.data = stat.regs.line_output_report;
            DFS_ADDR_STATE: st_d.data = stat.regs.channel_state_report;
            DFS_ADDR_CH_FAULT: st_d.data = stat.regs.channel_fault_flags;
            DFS_ADDR_GLB_FAULT: st_d.data = stat.regs.global_fault_flags_one;
            default: st_d.data = DFS_RST_ZERO;
         endcase
      end
   end

   // output register
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign rd_data_out = st_q.data;
   assign rd_valid_out = st_q.valid;
endmodule

// ==== logic/dfs_bank.sv ====
`timescale 1ns/100ps
//
// Contract
// RQ1: ch1/ch2 load results in bits 7..4, 3..0
// RQ2: channel 1/2 load report at 0x0c, resets zero
// RQ3: channel 3/4 load report at 0x0d, zero
// RQ4: line output bits 3..0 ch1..ch4, upper zero
// RQ5: two-bit state per channel, ch1 highest
// RQ6: state report at 0x0f resets 0x55
// RQ7: overcurrent bits 7..4, dc offset 3..0
// RQ8: global faults at 0x11, bits 7..5 zero
// RQ9: bit 0 follows battery undervoltage
// RQ10: all flags read-only, reset zero
// RQ11: ch3/ch4 dc bits are dc offset
module dfs_bank
   import dfs_pkg::*;
#(
   parameter int NUM_CH = DFS_NUM_CH // channel count
) (
   input wire logic clk_in, // clock, 100 MHz
   input wire logic reset_in, // sync reset, active high
   input wire logic [NUM_CH-1:0] short_to_ground_in, // per channel, bit0 = ch1
   input wire logic [NUM_CH-1:0] short_to_power_in, // per channel
   input wire logic [NUM_CH-1:0] open_load_in, // per channel
   input wire logic [NUM_CH-1:0] shorted_load_in, // per channel
   input wire logic [NUM_CH-1:0] line_output_detected_in, // per channel
   input wire logic [2*NUM_CH-1:0] channel_state_in, // 2 bits per channel, [1:0] = ch1
   input wire logic [NUM_CH-1:0] overcurrent_flag_in, // per channel
   input wire logic [NUM_CH-1:0] dc_offset_flag_in, // per channel
   input wire logic invalid_clock_in, // input clock fault
   input wire logic power_stage_overvoltage_in, // power-stage ov
   input wire logic battery_overvoltage_in, // battery ov
   input wire logic power_stage_undervoltage_in, // power-stage uv
   input wire logic battery_undervoltage_in, // battery uv
   input wire logic rd_en_in, // read strobe from control port
   input wire logic [DFS_ADDR_W-1:0] rd_addr_in, // register address
   output logic [DFS_DATA_W-1:0] rd_data_out, // read data, next cycle
   output logic rd_valid_out // read data valid
);
   dfs_regs_s regs_q, regs_d;
   dfs_status_if stat_if ();

   logic [7:0] load12_w, load34_w, line_w, state_w, chf_w, glb_w;

   // per-channel bit placement, ch1 in the most significant slot
   genvar ch;
   generate
      for (ch = 0; ch < DFS_NUM_CH; ch++) begin : g_ch
         localparam int SLOT = DFS_NUM_CH - 1 - ch;
         localparam int NIB = (ch % 2 == 0) ? DFS_NIBBLE_W : 0;
         if (ch < 2) begin : g_lo
            assign load12_w[NIB+DFS_LOAD_S2G_BIT] = short_to_ground_in[ch]; // [RQ1]
            assign load12_w[NIB+DFS_LOAD_S2P_BIT] = short_to_power_in[ch]; // [RQ1]
            assign load12_w[NIB+DFS_LOAD_OL_BIT] = open_load_in[ch]; // [RQ1]
            assign load12_w[NIB+DFS_LOAD_SL_BIT] = shorted_load_in[ch]; // [RQ1]
         end else begin : g_hi
            assign load34_w[NIB+DFS_LOAD_S2G_BIT] = short_to_ground_in[ch]; // [RQ3]
            assign load34_w[NIB+DFS_LOAD_S2P_BIT] = short_to_power_in[ch]; // [RQ3]
            assign load34_w[NIB+DFS_LOAD_OL_BIT] = open_load_in[ch]; // [RQ3]
            assign load34_w[NIB+DFS_LOAD_SL_BIT] = shorted_load_in[ch]; // [RQ3]
         end
         assign line_w[SLOT] = line_output_detected_in[ch]; // [RQ4]
         assign state_w[2*SLOT+1:2*SLOT] = channel_state_in[2*ch+1:2*ch]; // [RQ5]
         assign chf_w[DFS_NIBBLE_W+SLOT] = overcurrent_flag_in[ch]; // [RQ7]
         assign chf_w[SLOT] = dc_offset_flag_in[ch]; // dc offset for all channels [RQ7] [RQ11]
      end
   endgenerate

   // reserved upper nibble of line output report
   assign line_w[7:DFS_NIBBLE_W] = '0; // [RQ4]

   // global faults, reserved bits zero
   always_comb begin
      glb_w = DFS_RST_ZERO; // [RQ8]
      glb_w[DFS_GLB_CLOCK_BIT] = invalid_clock_in; // [RQ8]
      glb_w[DFS_GLB_PSOV_BIT] = power_stage_overvoltage_in; // [RQ8]
      glb_w[DFS_GLB_BATOV_BIT] = battery_overvoltage_in; // [RQ8]
      glb_w[DFS_GLB_PSUV_BIT] = power_stage_undervoltage_in; // [RQ8]
      glb_w[DFS_GLB_BATUV_BIT] = battery_undervoltage_in; // [RQ9]
   end

   // next state: registers mirror the engines; no host write path exists
   always_comb begin
      regs_d = regs_q;
      regs_d.load_report_ch12 = load12_w; // [RQ10]
      regs_d.load_report_ch34 = load34_w;
      regs_d.line_output_report = line_w;
      regs_d.channel_state_report = state_w;
      regs_d.channel_fault_flags = chf_w;
      regs_d.global_fault_flags_one = glb_w;
   end

   // status registers with documented reset values
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         regs_q.load_report_ch12 <= DFS_RST_ZERO; // [RQ2]
         regs_q.load_report_ch34 <= DFS_RST_ZERO; // [RQ3]
         regs_q.line_output_report <= DFS_RST_ZERO; // [RQ10]
         regs_q.channel_state_report <= DFS_RST_STATE; // all channels high impedance [RQ6]
         regs_q.channel_fault_flags <= DFS_RST_ZERO; // [RQ7]
         regs_q.global_fault_flags_one <= DFS_RST_ZERO; // [RQ10]
      end else begin
         regs_q <= regs_d;
      end
   end

   assign stat_if.regs = regs_q;

   // read decode at the documented addresses
   dfs_read_mux u_read_mux (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .stat(stat_if.reader), // [RQ2] [RQ6] [RQ8]
      .rd_en_in(rd_en_in),
      .rd_addr_in(rd_addr_in),
      .rd_data_out(rd_data_out),
      .rd_valid_out(rd_valid_out)
   );
endmodule

// ==== verification/dfs_bank_sva.sv ====
`timescale 1ns/100ps
module dfs_bank_sva #(
   parameter int NUM_CH = 4 // channel count
) (
   input wire logic clk_in, // clock
   input wire logic reset_in, // reset
   input wire logic [2*NUM_CH-1:0] channel_state_in, // states
   input wire logic [NUM_CH-1:0] short_to_ground_in, // ground short
   input wire logic [NUM_CH-1:0] short_to_power_in, // power short
   input wire logic [NUM_CH-1:0] open_load_in, // open
   input wire logic [NUM_CH-1:0] shorted_load_in, // shorted
   input wire logic [NUM_CH-1:0] line_output_detected_in, // line out
   input wire logic [NUM_CH-1:0] overcurrent_flag_in, // oc
   input wire logic [NUM_CH-1:0] dc_offset_flag_in, // dc
   input wire logic invalid_clock_in, // fault
   input wire logic power_stage_overvoltage_in, // fault
   input wire logic battery_overvoltage_in, // fault
   input wire logic power_stage_undervoltage_in, // fault
   input wire logic battery_undervoltage_in, // fault
   input wire logic rd_en_in, // strobe
   input wire logic [7:0] rd_addr_in, // address
   input wire logic [7:0] rd_data_out, // data
   input wire logic rd_valid_out // valid
);
   // inputs rearranged into register bit order
   wire logic [4:0] glb = {invalid_clock_in, power_stage_overvoltage_in, battery_overvoltage_in,
      power_stage_undervoltage_in, battery_undervoltage_in};
   wire logic [7:0] st_r = {channel_state_in[1:0], channel_state_in[3:2], channel_state_in[5:4],
      channel_state_in[7:6]};
   wire logic [3:0] oc_r = {overcurrent_flag_in[0], overcurrent_flag_in[1], overcurrent_flag_in[2],
      overcurrent_flag_in[3]};
   wire logic [3:0] dc_r = {dc_offset_flag_in[0], dc_offset_flag_in[1], dc_offset_flag_in[2],
      dc_offset_flag_in[3]};
   wire logic [7:0] ld12 = {short_to_ground_in[0], short_to_power_in[0], open_load_in[0], shorted_load_in[0],
      short_to_ground_in[1], short_to_power_in[1], open_load_in[1], shorted_load_in[1]};
   wire logic [7:0] ld34 = {short_to_ground_in[2], short_to_power_in[2], open_load_in[2], shorted_load_in[2],
      short_to_ground_in[3], short_to_power_in[3], open_load_in[3], shorted_load_in[3]};
   wire logic [3:0] lo_r = {line_output_detected_in[0], line_output_detected_in[1], line_output_detected_in[2],
      line_output_detected_in[3]};
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   valid_pulse_a: assert property (rd_en_in |=> rd_valid_out)
      else $error("no valid");
   valid_idle_a: assert property (!rd_en_in |=> !rd_valid_out)
      else $error("stray valid");
   data_hold_a: assert property (!rd_en_in |=> $stable(rd_data_out))
      else $error("data moved");
   rst_clear_a: assert property (disable iff (1'b0) reset_in |=> !rd_valid_out && rd_data_out == 8'h00)
      else $error("reset output");
   unmapped_zero_a: assert property (rd_en_in && (rd_addr_in < 8'h0c || rd_addr_in > 8'h11)
      |=> rd_data_out == 8'h00) else $error("unmapped");
   load12_map_a: assert property (rd_en_in && rd_addr_in == 8'h0c && !$past(reset_in)
      |=> rd_data_out == $past(ld12, 2)) else $error("load ch12");
   load34_map_a: assert property (rd_en_in && rd_addr_in == 8'h0d && !$past(reset_in)
      |=> rd_data_out == $past(ld34, 2)) else $error("load ch34");
   line_map_a: assert property (rd_en_in && rd_addr_in == 8'h0e && !$past(reset_in)
      |=> rd_data_out == {4'h0, $past(lo_r, 2)}) else $error("line out");
   state_rst_a: assert property (rd_en_in && rd_addr_in == 8'h0f && $past(reset_in)
      |=> rd_data_out == 8'h55) else $error("state reset");
   load_rst_a: assert property (rd_en_in && rd_addr_in == 8'h0c && $past(reset_in)
      |=> rd_data_out == 8'h00) else $error("load reset");
   state_map_a: assert property (rd_en_in && rd_addr_in == 8'h0f && !$past(reset_in)
      |=> rd_data_out == $past(st_r, 2)) else $error("state");
   ch_fault_a: assert property (rd_en_in && rd_addr_in == 8'h10 && !$past(reset_in)
      |=> rd_data_out == {$past(oc_r, 2), $past(dc_r, 2)}) else $error("ch fault");
   glb_fault_a: assert property (rd_en_in && rd_addr_in == 8'h11 && !$past(reset_in)
      |=> rd_data_out == {3'h0, $past(glb, 2)}) else $error("glb fault");
endmodule
bind dfs_bank dfs_bank_sva #(.NUM_CH(NUM_CH)) chk (.*);

// ==== verification/dfs_host.sv ====
`timescale 1ns/100ps
module dfs_host (
   input wire logic clk_in, // clock
   output logic rd_en_out, // strobe
   output logic [7:0] rd_addr_out, // address
   input wire logic [7:0] rd_data_in, // data
   input wire logic rd_valid_in // valid
);
   // idle until the first read
   initial rd_en_out = 1'b0;
   initial rd_addr_out = 8'h00;
   // one strobe, then take data at the edge where valid is sampled high
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      rd_en_out = 1'b1;
      rd_addr_out = a;
      @(posedge clk_in) #1;
      rd_en_out = 1'b0;
      rd_addr_out = ~a;
      @(posedge clk_in);
      d = rd_valid_in ? rd_data_in : 8'hxx;
      #1;
   endtask
endmodule

// ==== verification/test_diag_fault_status_bank.sv ====
`timescale 1ns/100ps
module test_diag_fault_status_bank;
   logic clk_in = 0;
   logic reset_in = 1;
   logic [3:0] sg, sp, ol, sl, lo, oc, dc;
   logic [7:0] st, d, ra, rdd;
   logic [4:0] gf;
   logic rd_en, rdv;
   int fails = 0;
   int cmp_count = 0;
   int cyc = 0;
   // address and expected data; rows 8 on use the all-ones pattern
   logic [15:0] rows [16] = '{16'h0b00, 16'h0c84, 16'h0d21, 16'h0e0c, 16'h0f1b, 16'h10a2, 16'h1115,
      16'h1200, 16'h0cff, 16'h0dff, 16'h0e0f, 16'h0fff, 16'h10ff, 16'h111f, 16'hff00, 16'h0000};
   // clock
   always #5 clk_in = ~clk_in;
   dfs_bank uut (.clk_in(clk_in), .reset_in(reset_in), .short_to_ground_in(sg), .short_to_power_in(sp),
      .open_load_in(ol), .shorted_load_in(sl), .line_output_detected_in(lo), .channel_state_in(st),
      .overcurrent_flag_in(oc), .dc_offset_flag_in(dc), .invalid_clock_in(gf[4]),
      .power_stage_overvoltage_in(gf[3]), .battery_overvoltage_in(gf[2]),
      .power_stage_undervoltage_in(gf[1]), .battery_undervoltage_in(gf[0]),
      .rd_en_in(rd_en), .rd_addr_in(ra), .rd_data_out(rdd), .rd_valid_out(rdv));
   dfs_host host (.clk_in(clk_in), .rd_en_out(rd_en), .rd_addr_out(ra), .rd_data_in(rdd), .rd_valid_in(rdv));
   // fault pattern: a different load bit per channel plus mixed line, oc, dc, state and global bits, or all ones
   task automatic set(input logic p);
      {sg, sp, ol, sl, lo, oc, dc, st, gf} = p ? '1 : {28'h1248354, 8'he4, 5'h15};
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic finish_test;
      $display("cmp_count=%0d fails=%0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // hang guard
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 500) begin
         fails++;
         finish_test;
      end
   end
   // main sequence
   initial begin
      set(0);
      repeat (5) @(posedge clk_in);
      #1 reset_in = 0;
      host.rd(8'h0f, d);
      chk("state_rst", 8'h55, d);
      foreach (rows[i]) begin
         set(i > 7);
         @(posedge clk_in) #1;
         host.rd(rows[i][15:8], d);
         chk("rd_data", rows[i][7:0], d);
      end
      reset_in = 1;
      @(posedge clk_in) #1 reset_in = 0;
      host.rd(8'h0c, d);
      chk("load_rst", 8'h00, d);
      finish_test;
   end
endmodule
